//--- logic/iste_top.sv
// Supply mapping, short-circuit test and pair evaluation of a 16-channel safe input
`timescale 1ns/1ps
`include "iste_defs.svh"

module iste_top #(
  parameter int GAP_TICKS = `ISTE_GAP_TICKS
) (
  // Clock and reset
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  // AXI4-Lite write
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  // Field side
  input  wire logic [15:0]          din,
  output logic [3:0]                supply_on,
  // Safety controller side
  output iste_pkg::iste_proc_t      proc
);
  import iste_pkg::*;

  iste_state_t s_q;
  iste_state_t s_d;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Supply index feeding group g, or none
  function automatic logic [2:0] grp_sup(input logic [31:0] c, input int g);
    logic [2:0] r;
    r = 3'(g);
    case (c[`ISTE_F_MODE])
      `ISTE_MRG_LO:   r = (g < 2) ? 3'h0 : 3'(g);
      `ISTE_MRG_HI:   r = (g >= 2) ? 3'h2 : 3'(g);
      `ISTE_MRG_BOTH: r = (g < 2) ? 3'h0 : 3'h2;
      `ISTE_MRG_ALL:  r = 3'h0;
      default:        r = 3'(g);
    endcase
    if (c[3 + g]) begin
      r = `ISTE_NO_SUP;
    end
    return r;
  endfunction

  // Channels fed by supply s, always whole groups
  function automatic logic [15:0] sup_mask(input logic [31:0] c, input int s);
    logic [15:0] m;
    m = 16'h0;
    for (int g = 0; g < 4; g++) begin
      if (grp_sup(c, g) == 3'(s)) begin
        m[4*g +: 4] = 4'hf;
      end
    end
    return m;
  endfunction

  // Input delay of a channel in ticks, taken from the lower channel
  function automatic logic [7:0] dly_tk(input logic [31:0] d, input int ch);
    return 8'(d[4*(ch % 8) +: 4] * `ISTE_DLY_UNIT);
  endfunction

  // Byte-lane merge of a write
  function automatic logic [31:0] wmerge(input logic [31:0] o,
                                         input logic [31:0] n,
                                         input logic [3:0]  b);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (b[i]) begin
        r[8*i +: 8] = n[8*i +: 8];
      end
    end
    return r;
  endfunction

  // Times are refused unless they clear the longest input delay
  function automatic logic cfg_ok(input logic [31:0] d, input logic [31:0] t);
    logic [7:0]  mx;
    logic [11:0] off;
    logic [11:0] st;
    mx = 8'h0;
    for (int i = 0; i < 8; i++) begin
      if (dly_tk(d, i) > mx) begin
        mx = dly_tk(d, i);
      end
    end
    off = t[`ISTE_F_OFF];
    st = t[`ISTE_F_START];
    cfg_ok = (off >= 12'(mx) + 12'(`ISTE_MARGIN_TK))
          && (st >= 12'(mx) + 12'(`ISTE_MARGIN_TK))
          && (20'(st) * 20'(`ISTE_PCT) >= 20'(off));
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [15:0] eff;
    logic [15:0] val;
    logic [15:0] fail;
    logic [15:0] w1c_sc;
    logic [7:0]  w1c_de;
    logic [15:0] m;
    logic        a;
    logic        b;
    logic        agree;
    logic [1:0]  ev;
    logic        do_wr;
    logic [7:0]  set_de;
    eff = 16'h0;
    set_de = 8'h0;
    val = 16'h0;
    fail = 16'h0;
    w1c_sc = 16'h0;
    w1c_de = 8'h0;
    m = 16'h0;
    a = 1'b0;
    b = 1'b0;
    agree = 1'b0;
    ev = 2'h0;
    do_wr = 1'b0;
    s_d = s_q;
    s_d.proc.diag_irq = 1'b0;

    // Bus: address and data taken in either order, answered once both are in
    if (s_q.awready && s_axi_awvalid) begin
      s_d.aw_have = 1'b1;
      s_d.aw_addr = s_axi_awaddr;
      s_d.awready = 1'b0;
    end
    if (s_q.wready && s_axi_wvalid) begin
      s_d.w_have = 1'b1;
      s_d.w_data = s_axi_wdata;
      s_d.w_strb = s_axi_wstrb;
      s_d.wready = 1'b0;
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
      s_d.awready = 1'b1;
      s_d.wready = 1'b1;
    end
    do_wr = s_q.aw_have && s_q.w_have && !s_q.bvalid;
    if (do_wr) begin
      s_d.aw_have = 1'b0;
      s_d.w_have = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = 2'b00;
      if (s_q.aw_addr == `ISTE_A_CTRL) begin
        s_d.ctrl = wmerge(s_q.ctrl, s_q.w_data, s_q.w_strb);
      end else if (s_q.aw_addr == `ISTE_A_EVAL) begin
        s_d.eval = wmerge(s_q.eval, s_q.w_data, s_q.w_strb);
      end else if (s_q.aw_addr == `ISTE_A_DELAY) begin
        s_d.delay = wmerge(s_q.delay, s_q.w_data, s_q.w_strb);
      end else if (s_q.aw_addr == `ISTE_A_TTIME) begin
        s_d.ttime = wmerge(s_q.ttime, s_q.w_data, s_q.w_strb);
      end else if (s_q.aw_addr == `ISTE_A_DTIME) begin
        s_d.dtime = wmerge(s_q.dtime, s_q.w_data, s_q.w_strb);
      end else if (s_q.aw_addr == `ISTE_A_ALARM) begin
        w1c_sc = 16'(wmerge(32'h0, s_q.w_data, s_q.w_strb));
        w1c_de = 8'(wmerge(32'h0, s_q.w_data, s_q.w_strb) >> 16);
      end else if (s_q.aw_addr == `ISTE_A_VALUE) begin
        s_d.bresp = 2'b00; // Read-only, write ignored
      end else begin
        s_d.bresp = 2'b10;
      end
    end

    // Bus read: one cycle to the answer
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
      s_d.arready = 1'b1;
    end
    if (s_q.arready && s_axi_arvalid) begin
      s_d.arready = 1'b0;
      s_d.rvalid = 1'b1;
      s_d.rresp = 2'b00;
      s_d.rdata = 32'h0;
      if (s_axi_araddr == `ISTE_A_CTRL) begin
        s_d.rdata = s_q.ctrl;
      end else if (s_axi_araddr == `ISTE_A_EVAL) begin
        s_d.rdata = s_q.eval;
      end else if (s_axi_araddr == `ISTE_A_DELAY) begin
        s_d.rdata = s_q.delay;
      end else if (s_axi_araddr == `ISTE_A_TTIME) begin
        s_d.rdata = s_q.ttime;
      end else if (s_axi_araddr == `ISTE_A_DTIME) begin
        s_d.rdata = s_q.dtime;
      end else if (s_axi_araddr == `ISTE_A_ALARM) begin
        s_d.rdata = {7'h0, s_q.cfg_err, s_q.disc_err, s_q.sc_alarm};
      end else if (s_axi_araddr == `ISTE_A_VALUE) begin
        s_d.rdata = {12'h0, s_q.sup_on, s_q.proc.value};
      end else begin
        s_d.rresp = 2'b10;
      end
    end

    // 0.1 ms tick from the clock divider
    s_d.tick = (s_q.pre == 10'(`ISTE_TICK_CYC - 1));
    s_d.pre = s_d.tick ? 10'h0 : s_q.pre + 10'h1;

    // Input filter: a level must stand a full delay before it is passed
    for (int i = 0; i < 16; i++) begin
      if (din[i] == s_q.filt[i]) begin
        s_d.fcnt[i] = 8'h0;
      end else if (dly_tk(s_q.delay, i) == 8'h0
                   || (s_q.tick && s_q.fcnt[i] + 8'h1 >= dly_tk(s_q.delay, i))) begin
        s_d.filt[i] = din[i];
        s_d.fcnt[i] = 8'h0;
      end else if (s_q.tick) begin
        s_d.fcnt[i] = s_q.fcnt[i] + 8'h1;
      end
    end

    // Test sequencer; a bad time setting blocks the test, not the inputs
    s_d.cfg_err = s_q.ctrl[`ISTE_F_TEN] && !cfg_ok(s_q.delay, s_q.ttime);
    case (s_q.phase)
      ST_GAP: begin
        if (s_q.tick) begin
          s_d.tcnt = s_q.tcnt + 16'h1;
        end
        if (s_q.tick && s_q.tcnt + 16'h1 >= 16'(GAP_TICKS)) begin
          s_d.tcnt = 16'h0;
          s_d.sup = s_q.sup + 2'h1;
          m = sup_mask(s_q.ctrl, int'(s_q.sup));
          if (s_q.ctrl[`ISTE_F_TEN] && !s_d.cfg_err && m != 16'h0) begin
            s_d.sup = s_q.sup;
            s_d.tmask = m;
            s_d.hold = s_q.filt;
            s_d.low_seen = 16'h0;
            s_d.phase = ST_OFF;
          end
        end
      end
      ST_OFF: begin
        s_d.low_seen = s_q.low_seen | (~din & s_q.tmask);
        if (s_q.tick) begin
          s_d.tcnt = s_q.tcnt + 16'h1;
        end
        if (s_q.tick && s_q.tcnt + 16'h1 >= 16'(s_q.ttime[`ISTE_F_OFF])) begin
          fail = s_q.tmask & ~s_d.low_seen;
          s_d.proc.diag_irq = (fail != 16'h0);
          s_d.sc_alarm = s_q.sc_alarm | fail;
          s_d.tcnt = 16'h0;
          s_d.phase = ST_START;
        end
      end
      ST_START: begin
        if (s_q.tick) begin
          s_d.tcnt = s_q.tcnt + 16'h1;
        end
        if (s_q.tick && s_q.tcnt + 16'h1 >= 16'(s_q.ttime[`ISTE_F_START])) begin
          s_d.tcnt = 16'h0;
          s_d.tmask = 16'h0;
          s_d.sup = s_q.sup + 2'h1;
          s_d.phase = ST_GAP;
        end
      end
      default: begin
        s_d.phase = ST_GAP;
      end
    endcase

    // Supplies: on when they feed a group, off only in the off phase
    for (int s = 0; s < 4; s++) begin
      s_d.sup_on[s] = (sup_mask(s_q.ctrl, s) != 16'h0)
                    && !(s_d.phase == ST_OFF && s_d.sup == 2'(s));
    end

    // Held value stands for tested channels until startup ends
    eff = (s_q.phase == ST_GAP) ? s_q.filt
        : (s_q.hold & s_q.tmask) | (s_q.filt & ~s_q.tmask);

    // Pair evaluation; upper bit of an equivalent or non-equivalent pair reads zero
    for (int p = 0; p < 8; p++) begin
      a = eff[p];
      b = eff[p + 8];
      ev = s_q.eval[2*p +: 2];
      if (ev == `ISTE_EV_EQ || ev == `ISTE_EV_NEQ) begin
        agree = (ev == `ISTE_EV_EQ) ? (a == b) : (a != b);
        if (agree) begin
          val[p] = a;
          s_d.last_val[p] = a;
          s_d.dcnt[p] = 12'h0;
        end else begin
          val[p] = s_q.last_val[p];
          if (s_q.tick) begin
            s_d.dcnt[p] = s_q.dcnt[p] + 12'h1;
          end
          if (s_q.tick && s_q.dcnt[p] + 12'h1 >= s_q.dtime[`ISTE_F_DISC]) begin
            set_de[p] = 1'b1;
            s_d.proc.diag_irq = s_d.proc.diag_irq | ~s_q.disc_err[p]; // Only a new error
          end
        end
        val[p + 8] = 1'b0;
      end else begin
        val[p] = a;
        val[p + 8] = b;
        s_d.last_val[p] = a;
        s_d.dcnt[p] = 12'h0;
      end
    end

    // Acknowledge clears alarms, but a new event in the same cycle wins
    s_d.sc_alarm = (s_q.sc_alarm & ~w1c_sc) | fail;
    s_d.disc_err = (s_q.disc_err & ~w1c_de) | set_de;

    // Passivated channels deliver zero
    s_d.proc.passiv = s_d.sc_alarm | {s_d.disc_err, s_d.disc_err};
    s_d.proc.value = val & ~s_d.proc.passiv;
    s_d.proc.disc_err = s_d.disc_err;
    // Mode codes above non-equivalent fall back to single channel
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
      s_q.awready <= 1'b1;
      s_q.wready <= 1'b1;
      s_q.arready <= 1'b1;
      s_q.ctrl <= `ISTE_CTRL_RST;
      s_q.eval <= `ISTE_EVAL_RST;
      s_q.delay <= `ISTE_DELAY_RST;
      s_q.ttime <= `ISTE_TTIME_RST;
      s_q.dtime <= `ISTE_DTIME_RST;
      s_q.phase <= ST_GAP;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state register
  assign s_axi_awready = s_q.awready;
  assign s_axi_wready = s_q.wready;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = s_q.arready;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rresp = s_q.rresp;
  assign s_axi_rdata = s_q.rdata;
  assign supply_on = s_q.sup_on;
  assign proc = s_q.proc;

endmodule

//--- logic/iste_defs.svh
// Offsets, field positions, reset values and timing counts of the input test block
`ifndef ISTE_DEFS_SVH
`define ISTE_DEFS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define ISTE_A_CTRL   8'h00
`define ISTE_A_EVAL   8'h04
`define ISTE_A_DELAY  8'h08
`define ISTE_A_TTIME  8'h0c
`define ISTE_A_DTIME  8'h10
`define ISTE_A_ALARM  8'h14
`define ISTE_A_VALUE  8'h18

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define ISTE_CTRL_RST  32'h0000_0000
`define ISTE_EVAL_RST  32'h0000_0000
`define ISTE_DELAY_RST 32'h1111_1111
`define ISTE_TTIME_RST 32'h000a_0014
`define ISTE_DTIME_RST 32'h0000_0064

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ISTE_F_MODE   2:0
`define ISTE_F_EXT    6:3
`define ISTE_F_TEN    7
`define ISTE_F_OFF    11:0
`define ISTE_F_START  27:16
`define ISTE_F_DISC   11:0

// Supply split codes
`define ISTE_SPLIT    3'h0
`define ISTE_MRG_LO   3'h1
`define ISTE_MRG_HI   3'h2
`define ISTE_MRG_BOTH 3'h3
`define ISTE_MRG_ALL  3'h4
`define ISTE_NO_SUP   3'h4

// Evaluation codes per pair
`define ISTE_EV_SINGLE 2'h0
`define ISTE_EV_EQ     2'h1
`define ISTE_EV_NEQ    2'h2

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define ISTE_CLK_MHZ    10
`define ISTE_TICK_US    100
`define ISTE_TICK_CYC   (`ISTE_TICK_US * `ISTE_CLK_MHZ)
`define ISTE_MARGIN_US  500
`define ISTE_MARGIN_TK  (`ISTE_MARGIN_US / `ISTE_TICK_US)
`define ISTE_DLY_UNIT   4
`define ISTE_PCT        100
`define ISTE_GAP_TICKS  1000

`endif

//--- logic/iste_pkg.sv
// Types shared by the input test block
package iste_pkg;

  // Test sequencer phases
  typedef enum logic [1:0] {
    ST_GAP,
    ST_OFF,
    ST_START
  } iste_phase_t;

  // Values handed to the safety controller
  typedef struct packed {
    logic [15:0] value;
    logic [15:0] passiv;
    logic [7:0]  disc_err;
    logic        diag_irq;
  } iste_proc_t;

  // Whole state of the block
  typedef struct packed {
    logic                awready;
    logic                wready;
    logic                bvalid;
    logic [1:0]          bresp;
    logic                arready;
    logic                rvalid;
    logic [1:0]          rresp;
    logic [31:0]         rdata;
    logic                aw_have;
    logic                w_have;
    logic [7:0]          aw_addr;
    logic [31:0]         w_data;
    logic [3:0]          w_strb;
    logic [31:0]         ctrl;
    logic [31:0]         eval;
    logic [31:0]         delay;
    logic [31:0]         ttime;
    logic [31:0]         dtime;
    logic [15:0]         sc_alarm;
    logic [7:0]          disc_err;
    logic                cfg_err;
    logic [9:0]          pre;
    logic                tick;
    logic [15:0][7:0]    fcnt;
    logic [15:0]         filt;
    iste_phase_t         phase;
    logic [1:0]          sup;
    logic [15:0]         tcnt;
    logic [15:0]         tmask;
    logic [15:0]         low_seen;
    logic [15:0]         hold;
    logic [7:0][11:0]    dcnt;
    logic [7:0]          last_val;
    logic [3:0]          sup_on;
    iste_proc_t          proc;
  } iste_state_t;

endpackage

//--- verification/iste_top_asserts.sv
// Port checks for the input test block
`timescale 1ns/1ps
module iste_top_asserts #(
  parameter int GAP_TICKS = 1000
) (
  // Clock and reset
  input wire logic                 aclk,
  input wire logic                 aresetn,
  // Register bus
  input wire logic                 s_axi_awvalid,
  input wire logic                 s_axi_awready,
  input wire logic                 s_axi_wvalid,
  input wire logic                 s_axi_wready,
  input wire logic                 s_axi_bvalid,
  input wire logic                 s_axi_bready,
  input wire logic [1:0]           s_axi_bresp,
  input wire logic                 s_axi_arvalid,
  input wire logic                 s_axi_arready,
  input wire logic                 s_axi_rvalid,
  input wire logic                 s_axi_rready,
  input wire logic [31:0]          s_axi_rdata,
  // Field and controller sides
  input wire logic [3:0]           supply_on,
  input wire iste_pkg::iste_proc_t proc
);
  import iste_pkg::*;

  // ------------------------------------------------
  // Everything here runs on the bus clock
  // ------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_wr_ans;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
  endproperty
  a_wr_ans: assert property (p_wr_ans)
    else $error("write answer late");
  property p_rd_ans;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_ans: assert property (p_rd_ans)
    else $error("read answer late");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write answer dropped");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read answer dropped");
  property p_busy;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_busy: assert property (p_busy)
    else $error("write taken while answer pending");
  // A passivated channel always delivers a low level
  property p_pas_zero;
    (proc.passiv & proc.value) == 16'h0000;
  endproperty
  a_pas_zero: assert property (p_pas_zero)
    else $error("passivated channel delivers high");
  property p_diag_new;
    |(proc.passiv & ~$past(proc.passiv)) |-> ##[0:1] proc.diag_irq;
  endproperty
  a_diag_new: assert property (p_diag_new)
    else $error("passivation without diagnostic event");
  property p_diag_one;
    proc.diag_irq |=> !proc.diag_irq;
  endproperty
  a_diag_one: assert property (p_diag_one)
    else $error("diagnostic event longer than one cycle");
  property p_disc_pas;
    (proc.disc_err & ~(proc.passiv[7:0] & proc.passiv[15:8])) == 8'h00;
  endproperty
  a_disc_pas: assert property (p_disc_pas)
    else $error("pair error without both channels passivated");
  // Group 0 keeps its pre-test value for eight cycles after its supply drops
  property p_held;
    $fell(supply_on[0]) |=> $stable(proc.value[3:0]) [*8];
  endproperty
  a_held: assert property (p_held)
    else $error("value not held while supply off");
endmodule

bind iste_top iste_top_asserts #(.GAP_TICKS(GAP_TICKS)) u_asserts (
  .aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .supply_on(supply_on), .proc(proc)
);

//--- verification/iste_field_model.sv
// Field switches and sensors fed by the block's sensor supplies
`timescale 1ns/1ps
module iste_field_model #(
  parameter int SETTLE = 300
) (
  // Clock
  input  wire logic        aclk,
  // Supplies and wiring
  input  wire logic [3:0]  supply_on,
  input  wire logic [2:0]  mode,
  input  wire logic [3:0]  ext,
  // Switches and faults
  input  wire logic [15:0] sw,
  input  wire logic [15:0] to_plus,
  // Input levels
  output logic [15:0]      din
);
  logic [3:0]      on_q;
  logic [3:0][9:0] wake_q;

  // Supply that feeds group g under split code m
  function automatic logic [1:0] src(input logic [2:0] m, input int g);
    logic [1:0] gg;
    gg = 2'(g);
    case (m)
      3'h1: return gg[1] ? gg : 2'h0;
      3'h2: return gg[1] ? 2'h2 : gg;
      3'h3: return {gg[1], 1'b0};
      3'h4: return 2'h0;
      default: return gg;
    endcase
  endfunction

  initial begin
    din = 16'h0000;
    on_q = 4'h0;
    wake_q = '0;
  end

  // Unpowered contacts sink low; a waking sensor toggles so no stale level survives
  always @(posedge aclk) begin
    for (int c = 0; c < 16; c++) begin
      if (to_plus[c]) din[c] <= 1'b1;                 // Shorted input ignores its supply
      else if (ext[c / 4]) din[c] <= sw[c];           // Fed from outside
      else if (!supply_on[src(mode, c / 4)]) din[c] <= 1'b0;
      else if (wake_q[src(mode, c / 4)] != 10'h0) din[c] <= ~din[c];
      else din[c] <= sw[c];
    end
    for (int s = 0; s < 4; s++) begin
      wake_q[s] <= (supply_on[s] && !on_q[s]) ? 10'(SETTLE)
                 : wake_q[s] - 10'(wake_q[s] != 10'h0);
    end
    on_q <= supply_on;
  end
endmodule

//--- verification/test_input_short_test_pair_eval.sv
// Self-checking bench for the input test block
`timescale 1ns/1ps
`include "iste_defs.svh"
module test_input_short_test_pair_eval;
  import iste_pkg::*;
  typedef struct packed { logic [15:0] ev; logic [15:0] s; logic [15:0] v; } iste_row_t;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb, supply_on, ext;
  logic [1:0]  bresp, rresp;
  logic [2:0]  mode;
  logic [15:0] din, sw, to_plus;
  iste_proc_t  proc;
  int          fails = 0, n_checks = 0, n_irq = 0, n;
  logic [7:0]  ra [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c};
  logic [31:0] rv [8] = '{`ISTE_CTRL_RST, `ISTE_EVAL_RST, `ISTE_DELAY_RST, `ISTE_TTIME_RST,
                          `ISTE_DTIME_RST, 32'h0, 32'h000f_0000, 32'h0};
  logic [7:0]  sc [7] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h18, 8'h61};
  logic [3:0]  se [7] = '{4'hf, 4'hd, 4'h7, 4'h5, 4'h1, 4'hc, 4'h1};
  logic [31:0] tt [5] = '{32'h0005_0004, 32'h0004_0005, 32'h0005_0005, 32'h0005_0258,
                          32'h0006_0258};
  logic        te [5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
  iste_row_t   rows [5] = '{{16'h0000, 16'ha5c3, 16'ha5c3}, {16'h5555, 16'h3c3c, 16'h003c},
                            {16'haaaa, 16'hc33c, 16'h003c}, {16'hffff, 16'h1234, 16'h1234},
                            {16'h0006, 16'hf2f3, 16'hf0f3}};

  iste_top #(.GAP_TICKS(2)) DUT (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .din(din), .supply_on(supply_on), .proc(proc)
  );
  iste_field_model u_field (
    .aclk(aclk), .supply_on(supply_on), .mode(mode), .ext(ext),
    .sw(sw), .to_plus(to_plus), .din(din)
  );

  // ------------------------------------------------
  // Shared tasks
  // ------------------------------------------------
  always #50 aclk = ~aclk;
  // Counts diagnostic events as the controller would see them
  always @(posedge aclk) if (proc.diag_irq === 1'b1) n_irq <= n_irq + 1;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic tk(input int t);
    repeat (t * `ISTE_TICK_CYC) @(posedge aclk);
  endtask
  // Trailing edge keeps a lowered ready apart from the next raise
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    awaddr <= a;
    wdata <= v;
    {awvalid, wvalid, bready} <= 3'h7;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er});
    @(posedge aclk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                     input logic [1:0] er);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    chk(rdata & m, e);
    chk({30'h0, rresp}, {30'h0, er});
    @(posedge aclk);
  endtask
  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Watchdog: the whole sequence needs about 34k cycles
  initial begin
    repeat (90000) @(posedge aclk);
    fails++;
    wrap_up;
  end

  // ------------------------------------------------
  // Main sequence
  // ------------------------------------------------
  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, sw, to_plus, mode, ext} = '0;
    wstrb = 4'hf;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (400) @(posedge aclk);
    chk({28'h0, supply_on}, 32'hf);
    for (int i = 0; i < 8; i++) rdc(ra[i], 32'hffff_ffff, rv[i], (i == 7) ? 2'h2 : 2'h0);
    wr(`ISTE_A_VALUE, 32'h0000_ffff, 2'h0);
    wr(8'h1c, 32'h0000_0001, 2'h2);
    // Split codes and external groups against the supplies switched on
    for (int i = 0; i < 7; i++) begin
      wr(`ISTE_A_CTRL, {24'h0, sc[i]}, 2'h0);
      mode <= sc[i][2:0];
      ext <= sc[i][6:3];
      repeat (3) @(posedge aclk);
      chk({28'h0, supply_on}, {28'h0, se[i]});
    end
    wr(`ISTE_A_CTRL, 32'h0, 2'h0);
    {mode, ext} <= '0;
    repeat (400) @(posedge aclk);
    wr(`ISTE_A_DELAY, 32'h0, 2'h0);
    // Evaluation modes, one row each
    for (int i = 0; i < 5; i++) begin
      wr(`ISTE_A_EVAL, {16'h0, rows[i].ev}, 2'h0);
      sw <= rows[i].s;
      tk(2);
      chk({16'h0, proc.value}, {16'h0, rows[i].v});
    end
    // Off time and startup limits against the margin and the startup ratio, input delay set to zero
    // Test enabled with every group external, so the limits count but no test starts
    ext <= 4'hf;
    wr(`ISTE_A_CTRL, 32'h0000_00f8, 2'h0);
    for (int i = 0; i < 5; i++) begin
      wr(`ISTE_A_TTIME, tt[i], 2'h0);
      repeat (2) @(posedge aclk);
      rdc(`ISTE_A_ALARM, 32'h0100_0000, {7'h0, te[i], 24'h0}, 2'h0);
    end
    wr(`ISTE_A_TTIME, 32'h0005_0005, 2'h0);
    wr(`ISTE_A_CTRL, 32'h0, 2'h0);
    ext <= '0;
    // Lasting pair disagreement
    wr(`ISTE_A_EVAL, 32'h1, 2'h0);
    wr(`ISTE_A_DTIME, 32'h3, 2'h0);
    sw <= 16'h0000;
    tk(2);
    sw <= 16'h0001;
    tk(1);
    chk({31'h0, proc.value[0]}, 32'h0);
    tk(4);
    chk({proc.disc_err, proc.passiv}, 32'h01_0101);
    sw <= 16'h0000;
    repeat (2) @(posedge aclk);
    wr(`ISTE_A_ALARM, 32'h00ff_0000, 2'h0);
    chk({proc.disc_err, proc.passiv}, 32'h0);
    // Short test: one supply feeds all, channel 5 stuck high, group 3 external
    wr(`ISTE_A_EVAL, 32'h0, 2'h0);
    sw <= 16'h00ff;
    to_plus <= 16'h1020;
    mode <= 3'h4;
    ext <= 4'h8;
    tk(2);
    wr(`ISTE_A_CTRL, 32'h0000_00c4, 2'h0);
    while (supply_on[0]) @(posedge aclk);
    n = 0;
    while (!supply_on[0]) begin
      n++;
      if (n == 2500) chk({28'h0, proc.value[3:0]}, 32'hf);
      @(posedge aclk);
    end
    chk(n, 5 * `ISTE_TICK_CYC);
    tk(3);
    chk({28'h0, proc.value[3:0]}, 32'hf);
    rdc(`ISTE_A_ALARM, 32'h00ff_ffff, 32'h0000_0020, 2'h0);
    chk({16'h0, proc.passiv}, 32'h0020);
    chk(n_irq, 2);
    // Second reset in mid-run clears supplies and delivered values
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    chk({supply_on, proc.value}, 32'h0);
    aresetn <= 1'b1;
    @(posedge aclk);
    wrap_up;
  end
endmodule
